// ### rtl/cmg_pkg.sv
// Purpose: shared constants and carriers for the channel mode and pin configuration block
// Assumes: byte-wide register port behind the serial interface engine
// Notes: offsets are register addresses of the register port
package cmg_pkg;

  localparam int unsigned CMG_NUM_CH = 8;
  localparam int unsigned CMG_AW = 8;
  localparam int unsigned CMG_DW = 8;

  // register addresses
  localparam logic [7:0] CMG_ADDR_OPMODE = 8'h04;
  localparam logic [7:0] CMG_ADDR_CHFUNC = 8'h05;
  localparam logic [7:0] CMG_ADDR_DIR = 8'h07;
  localparam logic [7:0] CMG_ADDR_DRIVE = 8'h09;
  localparam logic [7:0] CMG_ADDR_LEVEL = 8'h0b;
  localparam logic [7:0] CMG_ADDR_INLVL = 8'h0d;

  // reset value and value read back from unmapped addresses
  localparam logic [7:0] CMG_RST_VAL = 8'h00;
  localparam logic [7:0] CMG_UNMAPPED_VAL = 8'h00;

  // operating_mode_config fields
  localparam int unsigned CMG_OP_CONT_BIT = 7;
  localparam int unsigned CMG_OP_MODE_HI = 6;
  localparam int unsigned CMG_OP_MODE_LO = 5;
  localparam int unsigned CMG_OP_OSC_BIT = 4;
  localparam int unsigned CMG_OP_DIV_HI = 3;
  localparam int unsigned CMG_OP_DIV_LO = 0;

  // conversion_trigger_mode encodings
  localparam logic [1:0] CMG_MODE_MANUAL = 2'h0;
  localparam logic [1:0] CMG_MODE_AUTO = 2'h1;

  // oscillator_choice encodings
  localparam logic CMG_OSC_HIGH_SPEED = 1'b0;
  localparam logic CMG_OSC_LOW_POWER = 1'b1;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [CMG_AW-1:0] addr;
    logic [CMG_DW-1:0] wdata;
  } cmg_req_s;

  // pad drive toward the shared channel pins
  typedef struct packed {
    logic [CMG_NUM_CH-1:0] o;
    logic [CMG_NUM_CH-1:0] oe;
  } cmg_pad_s;

endpackage : cmg_pkg

// ### rtl/cmg_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs arrive asynchronous to ref_clk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module cmg_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : cmg_sync
`default_nettype wire

// ### rtl/cmg_top.sv
// Purpose: operating mode and per-channel pin configuration with pin drive and readback
// Assumes: crc_err_in is the sticky error flag on ref_clk; force_all_analog is a level on ref_clk
// Notes: pin drive and status outputs follow register or flag changes one edge later
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - with continue_after_crc_fault clear, a crc error leaves sequencing and pins as they are.
// RULE2 - with continue_after_crc_fault set, a crc error makes all channels analog and pauses.
// RULE3 - once the crc error flag clears, sequencing resumes and the pin setup comes back.
// RULE4 - conversion_trigger_mode 00 is manual (host starts), 01 is autonomous (machine starts).
// RULE5 - oscillator_choice 0 picks the high-speed oscillator, 1 the low-power one.
// RULE6 - the four-bit divider sets the sample rate while autonomous mode is selected.
// RULE7 - each channel-function bit makes its channel analog at 0 and a digital pin at 1.
// RULE8 - each direction bit makes its digital pin an input at 0 and an output at 1.
// RULE9 - each drive-type bit makes its output open-drain at 0 and push-pull at 1.
// RULE10 - each output-level bit gives the level driven on its digital output.
// RULE11 - the input readback register returns the present level of each pin.
// RULE12 - all configuration registers clear to zero on reset, so every channel starts analog.
// RULE13 - while force_all_analog is set, every channel is analog whatever the other settings.
// RULE14 - the host picks only analog channels for manual conversion.
// RULE15 - direction, drive and level act on a pin only while its channel is a digital pin.
// RULE16 - an open-drain output at 1 releases the pin and at 0 pulls it low.
module cmg_top
  import cmg_pkg::*;
#(
  parameter int unsigned NUM_CH = CMG_NUM_CH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire cmg_req_s reg_req,
  output logic [CMG_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  // control from the rest of the device
  input wire logic crc_err_in,
  input wire logic force_all_analog,
  // mode outputs
  output logic [1:0] conversion_trigger_mode,
  output logic autonomous_active,
  output logic oscillator_choice,
  output logic [3:0] sample_clk_div,
  output logic sequencing_hold,
  output logic [NUM_CH-1:0] analog_input_sel,
  // shared channel pins
  input wire logic [NUM_CH-1:0] pin_i,
  output cmg_pad_s pad
);

  if (NUM_CH != CMG_NUM_CH) begin : g_bad_width
    $error("cmg_top: NUM_CH must equal the register width");
  end

  // configuration registers
  logic [CMG_DW-1:0] opmode_q;
  logic [CMG_DW-1:0] opmode_d;
  logic [NUM_CH-1:0] chfunc_q;
  logic [NUM_CH-1:0] chfunc_d;
  logic [NUM_CH-1:0] dir_q;
  logic [NUM_CH-1:0] dir_d;
  logic [NUM_CH-1:0] drive_q;
  logic [NUM_CH-1:0] drive_d;
  logic [NUM_CH-1:0] level_q;
  logic [NUM_CH-1:0] level_d;

  // read side
  logic [CMG_DW-1:0] rdata_q;
  logic [CMG_DW-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // derived state
  logic [NUM_CH-1:0] in_sync;
  logic [NUM_CH-1:0] inlvl_q;
  logic [NUM_CH-1:0] inlvl_d;
  logic hold_q;
  logic hold_d;
  logic [NUM_CH-1:0] analog_q;
  logic [NUM_CH-1:0] analog_d;
  logic [NUM_CH-1:0] pad_o_q;
  logic [NUM_CH-1:0] pad_o_d;
  logic [NUM_CH-1:0] pad_oe_q;
  logic [NUM_CH-1:0] pad_oe_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic auto_q;
  logic auto_d;
  logic osc_q;
  logic osc_d;
  logic [3:0] div_q;
  logic [3:0] div_d;

  logic cont_bit;
  logic pause;
  logic [NUM_CH-1:0] digital;

  cmg_sync #(
    .WIDTH(NUM_CH)
  ) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_i(pin_i),
    .sync_o(in_sync)
  );

  // register writes; the readback register ignores writes
  always_comb begin
    opmode_d = opmode_q;
    chfunc_d = chfunc_q;
    dir_d = dir_q;
    drive_d = drive_q;
    level_d = level_q;
    if (reg_req.wr) begin
      case (reg_req.addr)
        CMG_ADDR_OPMODE: opmode_d = reg_req.wdata;
        CMG_ADDR_CHFUNC: chfunc_d = reg_req.wdata[NUM_CH-1:0];
        CMG_ADDR_DIR: dir_d = reg_req.wdata[NUM_CH-1:0];
        CMG_ADDR_DRIVE: drive_d = reg_req.wdata[NUM_CH-1:0];
        CMG_ADDR_LEVEL: level_d = reg_req.wdata[NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opmode_q <= CMG_RST_VAL; // RULE12
      chfunc_q <= CMG_RST_VAL; // RULE12
      dir_q <= CMG_RST_VAL;
      drive_q <= CMG_RST_VAL;
      level_q <= CMG_RST_VAL;
    end else begin
      opmode_q <= opmode_d;
      chfunc_q <= chfunc_d;
      dir_q <= dir_d;
      drive_q <= drive_d;
      level_q <= level_d;
    end
  end

  // register reads; unmapped addresses answer zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_req.rd;
    if (reg_req.rd) begin
      case (reg_req.addr)
        CMG_ADDR_OPMODE: rdata_d = opmode_q;
        CMG_ADDR_CHFUNC: rdata_d = chfunc_q;
        CMG_ADDR_DIR: rdata_d = dir_q;
        CMG_ADDR_DRIVE: rdata_d = drive_q;
        CMG_ADDR_LEVEL: rdata_d = level_q;
        CMG_ADDR_INLVL: rdata_d = inlvl_q; // RULE11
        default: rdata_d = CMG_UNMAPPED_VAL;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= CMG_RST_VAL;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // crc reaction and effective channel function
  // registers keep their contents during a pause, so restore needs no saved copy
  assign cont_bit = opmode_q[CMG_OP_CONT_BIT];
  assign pause = cont_bit & crc_err_in; // RULE1 RULE2 RULE3

  always_comb begin
    hold_d = pause; // RULE2 RULE3
    digital = chfunc_q; // RULE7
    if (force_all_analog || pause) begin
      digital = '0; // RULE13 RULE2
    end
    analog_d = ~digital; // RULE7
    mode_d = opmode_q[CMG_OP_MODE_HI:CMG_OP_MODE_LO];
    auto_d = (mode_d == CMG_MODE_AUTO); // RULE4
    osc_d = opmode_q[CMG_OP_OSC_BIT]; // RULE5
    div_d = opmode_q[CMG_OP_DIV_HI:CMG_OP_DIV_LO]; // RULE6
  end

  // per-pin drive
  for (genvar i = 0; i < NUM_CH; i++) begin : g_pin
    always_comb begin
      pad_o_d[i] = 1'b0;
      pad_oe_d[i] = 1'b0;
      if (digital[i] && dir_q[i]) begin // RULE15 RULE8
        pad_o_d[i] = level_q[i]; // RULE10
        pad_oe_d[i] = drive_q[i] | ~level_q[i]; // RULE9 RULE16
      end
    end
  end

  always_comb begin
    inlvl_d = in_sync; // RULE11
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 1'b0;
      analog_q <= '1;
      pad_o_q <= '0;
      pad_oe_q <= '0;
      inlvl_q <= '0;
      mode_q <= CMG_MODE_MANUAL;
      auto_q <= 1'b0;
      osc_q <= CMG_OSC_HIGH_SPEED;
      div_q <= '0;
    end else begin
      hold_q <= hold_d;
      analog_q <= analog_d;
      pad_o_q <= pad_o_d;
      pad_oe_q <= pad_oe_d;
      inlvl_q <= inlvl_d;
      mode_q <= mode_d;
      auto_q <= auto_d;
      osc_q <= osc_d;
      div_q <= div_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign sequencing_hold = hold_q;
  assign analog_input_sel = analog_q;
  assign pad = '{o: pad_o_q, oe: pad_oe_q};
  assign conversion_trigger_mode = mode_q;
  assign autonomous_active = auto_q;
  assign oscillator_choice = osc_q;
  assign sample_clk_div = div_q;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_paused;
    cont_bit && crc_err_in;
  endsequence

  sequence s_cleared;
    cont_bit && !crc_err_in && !force_all_analog && !reg_req.wr;
  endsequence

  AST_CONT_OFF_KEEPS: assert property ( // RULE1
    (!cont_bit && crc_err_in && !force_all_analog) |=>
      (!sequencing_hold && analog_input_sel == ~$past(chfunc_q)))
    else $error("crc error changed pins with continue bit clear");

  AST_PAUSE_ANALOG: assert property ( // RULE2
    s_paused |=> (sequencing_hold && (&analog_input_sel) && pad.oe == '0))
    else $error("crc pause did not force analog and hold");

  AST_RESUME: assert property ( // RULE3
    s_paused ##1 s_cleared |=>
      (!sequencing_hold && analog_input_sel == ~$past(chfunc_q)))
    else $error("pin setup not restored after crc flag clear");

  AST_MODE_AUTO: assert property ( // RULE4
    1'b1 |=> (autonomous_active ==
      ($past(opmode_q[CMG_OP_MODE_HI:CMG_OP_MODE_LO]) == CMG_MODE_AUTO)))
    else $error("autonomous flag does not follow mode field");

  AST_OSC: assert property ( // RULE5
    1'b1 |=> (oscillator_choice == $past(opmode_q[CMG_OP_OSC_BIT])))
    else $error("oscillator choice does not follow register");

  AST_DIV: assert property ( // RULE6
    (reg_req.wr && reg_req.addr == CMG_ADDR_OPMODE) |=> ##1
      (sample_clk_div == $past(reg_req.wdata[CMG_OP_DIV_HI:CMG_OP_DIV_LO], 2)))
    else $error("divider output does not follow written value");

  AST_FUNC: assert property ( // RULE7
    (!force_all_analog && !pause) |=> (analog_input_sel == ~$past(chfunc_q)))
    else $error("channel function not applied");

  AST_DIR_ONLY_OUT: assert property ( // RULE8
    1'b1 |=> ((pad.oe & ~$past(dir_q)) == '0))
    else $error("pin driven while set as input");

  AST_OD_NO_HIGH: assert property ( // RULE9
    1'b1 |=> ((pad.oe & pad.o & ~$past(drive_q)) == '0))
    else $error("open-drain output driven high");

  AST_LEVEL: assert property ( // RULE10
    1'b1 |=> ((pad.o & pad.oe) == ($past(level_q) & pad.oe)))
    else $error("driven level differs from level register");

  AST_READBACK: assert property ( // RULE11
    (rstn && $stable(pin_i))[*4] |-> (inlvl_q == $past(pin_i)))
    else $error("readback does not show pin level");

  AST_RESET_ZERO: assert property ( // RULE12
    $rose(rstn) |-> (opmode_q == '0 && chfunc_q == '0 && dir_q == '0 &&
      drive_q == '0 && level_q == '0))
    else $error("configuration not zero after reset");

  AST_FORCE: assert property ( // RULE13
    force_all_analog |=> ((&analog_input_sel) && pad.oe == '0))
    else $error("force analog not honoured");

  AST_GATE_FUNC: assert property ( // RULE15
    1'b1 |=> ((pad.oe & ~$past(chfunc_q)) == '0))
    else $error("analog channel pin driven");

  AST_OD_LOW: assert property ( // RULE16
    (!force_all_analog && !pause) |=>
      ((pad.oe & $past(chfunc_q & dir_q & ~drive_q & ~level_q)) ==
        $past(chfunc_q & dir_q & ~drive_q & ~level_q)))
    else $error("open-drain low not pulled");

endmodule : cmg_top
`default_nettype wire

// ### sim/cmg_pin_env.sv
// Purpose: board side of the shared channel pins
// Assumes: every pin carries an external pull-up
// Notes: an outside driver may take a pin the block leaves released
`timescale 1ns/1ps
`default_nettype none
module cmg_pin_env
  import cmg_pkg::*;
(
  // block drive
  input wire cmg_pad_s pad,
  // outside driver
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // resolved wire level
  output logic [7:0] pin_o
);
  // a released pin not taken by the outside driver floats up to the pull-up, never to a stale value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_o[i] = pad.oe[i] ? pad.o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : cmg_pin_env
`default_nettype wire

// ### sim/cmg_top_tb_top.sv
// Purpose: self-checking bench for the channel mode and pin block
// Assumes: byte strobe register port, pins resolved by the board model
// Notes: derived outputs are judged two edges after a write
`timescale 1ns/1ps
`default_nettype none
module cmg_top_tb_top;
  import cmg_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  cmg_req_s req = '0;
  logic [7:0] rdata, asel, pin, ext_en, ext_val;
  logic rvalid, auto, osc, hold;
  logic crc = 1'b0;
  logic frc = 1'b0;
  logic [1:0] mode;
  logic [3:0] div;
  cmg_pad_s pad;
  int bad_count = 0;
  int checks_done = 0;

  always #4 ref_clk = ~ref_clk;

  cmg_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .crc_err_in(crc), .force_all_analog(frc),
    .conversion_trigger_mode(mode), .autonomous_active(auto), .oscillator_choice(osc),
    .sample_clk_div(div), .sequencing_hold(hold), .analog_input_sel(asel),
    .pin_i(pin), .pad(pad));
  cmg_pin_env env_u (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_o(pin));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
  endtask : wr

  // waits on the read answer under a bound; a lost answer ends the run
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int i;
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '0;
    #1;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) settle(1);
    if (i == 4) begin
      bad_count++;
      tally_and_finish();
    end else begin
      chk(rdata, exp);
    end
  endtask : rd

  task automatic pins(input logic [7:0] e_sel, input logic [7:0] e_oe, input logic [7:0] e_o);
    chk(asel, e_sel);
    chk(pad.oe, e_oe);
    chk(pad.o & pad.oe, e_o);
  endtask : pins

  task automatic t_reset();
    rd(CMG_ADDR_OPMODE, 8'h00);
    rd(CMG_ADDR_CHFUNC, 8'h00);
    rd(CMG_ADDR_DIR, 8'h00);
    rd(CMG_ADDR_DRIVE, 8'h00);
    rd(CMG_ADDR_LEVEL, 8'h00);
    rd(8'h06, 8'h00);
    pins(8'hff, 8'h00, 8'h00);
  endtask : t_reset

  task automatic t_mode();
    wr(CMG_ADDR_OPMODE, 8'h3a);
    settle(2);
    chk({6'h0, mode}, 8'h01);
    chk({7'h0, auto}, 8'h01);
    chk({7'h0, osc}, 8'h01);
    chk({4'h0, div}, 8'h0a);
    rd(CMG_ADDR_OPMODE, 8'h3a);
    wr(CMG_ADDR_OPMODE, 8'h05);
    settle(2);
    chk({mode, auto, osc, div}, 8'h05);
    wr(CMG_ADDR_OPMODE, 8'h60);
    settle(2);
    chk({mode, auto, osc, div}, 8'hc0);
  endtask : t_mode

  // ch0/1 push-pull, ch2/4 open-drain, ch3 input, ch5-7 analog with stray settings
  task automatic t_pins();
    wr(CMG_ADDR_CHFUNC, 8'h1f);
    wr(CMG_ADDR_DIR, 8'hf7);
    wr(CMG_ADDR_DRIVE, 8'h03);
    wr(CMG_ADDR_LEVEL, 8'h05);
    settle(2);
    pins(8'he0, 8'h13, 8'h01);
    chk(asel & 8'h20, 8'h20);
    settle(4);
    rd(CMG_ADDR_INLVL, 8'he5);
    @(posedge ref_clk);
    ext_val <= 8'h08;
    wr(CMG_ADDR_INLVL, 8'h00);
    settle(4);
    rd(CMG_ADDR_INLVL, 8'hed);
    rd(CMG_ADDR_LEVEL, 8'h05);
  endtask : t_pins

  task automatic t_force();
    @(posedge ref_clk);
    frc <= 1'b1;
    settle(2);
    pins(8'hff, 8'h00, 8'h00);
    @(posedge ref_clk);
    frc <= 1'b0;
    settle(2);
    pins(8'he0, 8'h13, 8'h01);
  endtask : t_force

  task automatic t_crc();
    @(posedge ref_clk);
    crc <= 1'b1;
    settle(2);
    chk({7'h0, hold}, 8'h00);
    pins(8'he0, 8'h13, 8'h01);
    wr(CMG_ADDR_OPMODE, 8'ha0);
    settle(2);
    chk({7'h0, hold}, 8'h01);
    pins(8'hff, 8'h00, 8'h00);
    @(posedge ref_clk);
    crc <= 1'b0;
    settle(2);
    chk({7'h0, hold}, 8'h00);
    pins(8'he0, 8'h13, 8'h01);
  endtask : t_crc

  initial begin
    ext_en = 8'h08;
    ext_val = 8'h00;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    settle(1);
    t_reset();
    t_mode();
    t_pins();
    t_force();
    t_crc();
    tally_and_finish();
  end
endmodule : cmg_top_tb_top
`default_nettype wire
